// ---- src/vspi_pkg.sv ----
// Constants shared by the segment timing core and the packet link
package vspi_pkg;
  // Packet geometry
  localparam int HDR_BYTES = 4;
  localparam int RAW_PKT_BYTES = 164;
  localparam int RGB_PKT_BYTES = 244;
  localparam int ROW_PIXELS = 160;
  localparam int HALF_ROW_PIXELS = ROW_PIXELS / 2;
  localparam int RAW_BYTES_PER_PIX = 2;
  localparam int RGB_BYTES_PER_PIX = 3;
  // Segment and frame structure
  localparam int PKTS_PER_SEG = 60;
  localparam int PKTS_PER_SEG_TLM = 61;
  localparam int SEGS_PER_FRAME = 4;
  localparam int INVALID_FRAMES = 2;
  localparam logic [7:0] DISCARD_ID_HI = 8'h0f;
  // Timing pulse offset range, in line periods
  localparam int MAX_OFFSET_LINES = 3;
  // Timing, in the units printed, and derived cycle counts at the core rate
  localparam int CLK_MHZ = 100;
  localparam int SEG_PERIOD_US = 9434;
  localparam int LINE_PERIOD_US = 500;
  localparam int RESYNC_IDLE_MS = 185;
  localparam int PULSE_WIDTH_US = 1;
  localparam int SEG_CYC_DEF = SEG_PERIOD_US * CLK_MHZ;
  localparam int LINE_CYC_DEF = LINE_PERIOD_US * CLK_MHZ;
  // Strictly more than the idle time, so one cycle beyond it
  localparam int RESYNC_CYC_DEF = RESYNC_IDLE_MS * 1000 * CLK_MHZ + 1;
  localparam int PULSE_CYC = PULSE_WIDTH_US * CLK_MHZ;
  // Cycles the link logic is held in reset after an idle timeout
  localparam logic [2:0] LINK_RST_CYC = 3'h4;
endpackage

// ---- src/seg_link_if.sv ----
// Signals passed from the segment timing core to the packet link
`timescale 1ns/1ps
interface seg_link_if;
  logic seg_tgl; // Toggles once per segment-ready instant
  logic [2:0] seg_idx; // Segment index, stable between toggles
  logic tlm_en; // Telemetry enable level
  logic colour_fmt; // 1 selects the 24-bit colour format
  logic link_rst_n; // Async reset of the link logic, low active
  modport core (output seg_tgl, output seg_idx, output tlm_en, output colour_fmt,
                output link_rst_n);
  modport link (input seg_tgl, input seg_idx, input tlm_en, input colour_fmt,
                input link_rst_n);
endinterface

// ---- src/spi_packet_tx.sv ----
// Packet serialiser on the serial link clock
`timescale 1ns/1ps
module spi_packet_tx
  import vspi_pkg::*;
(
  // Serial link
  input wire logic i_spi_clk,
  input wire logic i_spi_cs_n,
  output logic o_spi_miso,
  // From the core
  seg_link_if.link lnk
);
  logic tgl_m_r, tgl_s_r, tgl_d_r; // Segment toggle synchroniser and delay
  logic tlm_m_r, tlm_s_r; // Telemetry level synchroniser
  logic rgb_m_r, rgb_s_r; // Format level synchroniser
  logic [2:0] bit_cnt_r; // Bit within byte
  logic [7:0] byte_cnt_r; // Byte within packet
  logic [5:0] pkt_r; // Packet number within segment
  logic video_r; // Current packet is a video packet
  logic pending_r; // A segment is ready but not yet started
  logic [2:0] pend_idx_r; // Index of the pending segment
  logic [2:0] tfield_r; // Index of the segment being sent
  logic lost_r; // Sync lost, only discards until timeout
  logic [7:0] pix_r; // Pixel within half row
  logic [1:0] sub_r; // Byte within pixel
  logic [7:0] shift_r; // Outgoing byte, MSB first

  // Decoding of the current position
  wire ready_evt = tgl_s_r ^ tgl_d_r;
  wire [7:0] pkt_len = rgb_s_r ? 8'(RGB_PKT_BYTES) : 8'(RAW_PKT_BYTES);
  wire [5:0] seg_last = tlm_s_r ? 6'(PKTS_PER_SEG_TLM - 1) : 6'(PKTS_PER_SEG - 1);
  wire [1:0] bpp_last = rgb_s_r ? 2'(RGB_BYTES_PER_PIX - 1) : 2'(RAW_BYTES_PER_PIX - 1);
  wire byte_end = (bit_cnt_r == 3'h7);
  wire pkt_end = byte_end && (byte_cnt_r == pkt_len - 8'h01);
  // Packet sequencing: finish the segment, else start a pending one
  wire cont = video_r && !lost_r && (pkt_r != seg_last);
  wire start = !cont && pending_r && !lost_r;
  // Segment ready before the last one was drained breaks sync
  wire lose = ready_evt && (video_r || pending_r);
  // Position and context of the next byte
  wire [7:0] nb_idx = pkt_end ? 8'h00 : byte_cnt_r + 8'h01;
  wire nb_video = pkt_end ? (cont || start) : video_r;
  wire [5:0] nb_pkt = (pkt_end && cont) ? pkt_r + 6'h01 : (pkt_end ? 6'h00 : pkt_r);
  wire [2:0] nb_t = (pkt_end && start) ? pend_idx_r : tfield_r;
  wire nb_first = (nb_idx <= 8'(HDR_BYTES));
  wire [1:0] nb_sub = (nb_first || sub_r == bpp_last) ? 2'h0 : sub_r + 2'h1;
  wire [7:0] nb_pix = nb_first ? 8'h00 : ((sub_r == bpp_last) ? pix_r + 8'h01 : pix_r);
  // Two packets per row: row from packet number, half from its low bit
  wire [7:0] nb_row = {3'h0, nb_pkt[5:1]};
  wire [7:0] nb_col = (nb_pkt[0] ? 8'(HALF_ROW_PIXELS) : 8'h00) + nb_pix;
  // Payload is a row and column test pattern; no pixel source here
  wire [7:0] pay_byte = (nb_sub == 2'h0) ? nb_row : ((nb_sub == 2'h1) ? nb_col : {2'h0, nb_pkt});
  // Header carries the segment index in the top nibble; checksum sent as zero
  wire [7:0] nb_byte = (nb_idx == 8'h00) ? (nb_video ? {1'b0, nb_t, 4'h0} : DISCARD_ID_HI) :
                       (nb_idx == 8'h01) ? (nb_video ? {2'h0, nb_pkt} : 8'h00) :
                       (nb_idx < 8'(HDR_BYTES)) ? 8'h00 :
                       (nb_video ? pay_byte : 8'h00);

  assign o_spi_miso = shift_r[7];

  // Level and event synchronisers, also cleared by the timeout reset
  always_ff @(posedge i_spi_clk or negedge lnk.link_rst_n) begin
    if (!lnk.link_rst_n) begin
      {tgl_m_r, tgl_s_r, tgl_d_r} <= 3'h0;
      {tlm_m_r, tlm_s_r, rgb_m_r, rgb_s_r} <= 4'h0;
    end else begin
      {tgl_m_r, tgl_s_r, tgl_d_r} <= {lnk.seg_tgl, tgl_m_r, tgl_s_r};
      {tlm_m_r, tlm_s_r, rgb_m_r, rgb_s_r} <= {lnk.tlm_en, tlm_m_r, lnk.colour_fmt, rgb_m_r};
    end
  end

  // Segment bookkeeping; a new ready beats a start in the same cycle
  always_ff @(posedge i_spi_clk or negedge lnk.link_rst_n) begin
    if (!lnk.link_rst_n) begin
      pending_r <= 1'b0;
      pend_idx_r <= 3'h0;
      lost_r <= 1'b0;
    end else begin
      if (lose) begin
        lost_r <= 1'b1;
      end
      if (ready_evt) begin
        pending_r <= 1'b1;
        pend_idx_r <= lnk.seg_idx;
      end else if (!i_spi_cs_n && pkt_end && start) begin
        pending_r <= 1'b0;
      end
    end
  end

  // Shifter and packet counters; restart at a discard after the timeout
  always_ff @(posedge i_spi_clk or negedge lnk.link_rst_n) begin
    if (!lnk.link_rst_n) begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 8'h00;
      pkt_r <= 6'h00;
      video_r <= 1'b0;
      tfield_r <= 3'h0;
      pix_r <= 8'h00;
      sub_r <= 2'h0;
      shift_r <= DISCARD_ID_HI;
    end else if (!i_spi_cs_n) begin
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_end) begin
        byte_cnt_r <= nb_idx;
        pkt_r <= nb_pkt;
        video_r <= nb_video;
        tfield_r <= nb_t;
        pix_r <= nb_pix;
        sub_r <= nb_sub;
        shift_r <= nb_byte;
      end else begin
        shift_r <= {shift_r[6:0], 1'b0};
      end
    end
  end

  logic [7:0] nb_row_q; // Row expected from the packet number now in use
  assign nb_row_q = {3'h0, pkt_r[5:1]};

  default clocking cb @(posedge i_spi_clk); endclocking
  default disable iff (!lnk.link_rst_n);
  a_pkt_len_wrap: assert property (!i_spi_cs_n && pkt_end |=> byte_cnt_r == 8'h00)
    else $error("packet did not end at its documented length");
  a_pkt_count_max: assert property (video_r |-> pkt_r <= seg_last)
    else $error("segment holds more packets than allowed");
  a_half_row_hdr: assert property (!i_spi_cs_n && byte_end && nb_video && nb_idx == 8'h04
    |=> shift_r == nb_row_q)
    else $error("payload row is not packet number halved");
endmodule

// ---- src/video_spi_segment_sync.sv ----
// Segment timing core of the video link, with the frame timing pulse
`timescale 1ns/1ps
// Function
// - Pulse only when sync pin mode selected
// - Pulse offset from minus three to plus three lines
// - Offset is zero after reset
// - Packet is 164 or 244 bytes
// - Each packet carries half a row
// - Two invalid frames follow every unique frame
// - One pulse per segment
// - Telemetry adds one packet per segment
// - Segment index 1 to 4, then zeros
// - Long deselect restarts packet transmission
// - Segment has 60 or 61 packets
module video_spi_segment_sync
  import vspi_pkg::*;
#(
  parameter int SEG_CYC = SEG_CYC_DEF, // Segment period in core cycles
  parameter int LINE_CYC = LINE_CYC_DEF, // Line period in core cycles
  parameter int RESYNC_CYC = RESYNC_CYC_DEF // Idle deselect time for resync
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // Serial link, on its own clock
  input wire logic i_spi_clk,
  input wire logic i_spi_cs_n,
  output logic o_spi_miso,
  // Settings from the camera_control_interface
  input wire logic i_vsync_mode,
  input wire logic i_telemetry_en,
  input wire logic i_colour_fmt,
  input wire logic i_offset_load,
  input wire logic [2:0] i_pulse_offset,
  // general_pin_three, output side only
  output logic o_general_pin_three,
  output logic o_general_pin_three_oe
);
  localparam int CW = $clog2(SEG_CYC + 1);
  localparam int RW = $clog2(RESYNC_CYC + 1);
  localparam int PW = $clog2(PULSE_CYC + 1);

  seg_link_if lnk ();

  logic cs_m_r, cs_s_r; // Select synchroniser, idle high
  logic [RW-1:0] idle_cnt_r; // Cycles of continuous deselect
  logic [2:0] link_rst_cnt_r; // Link reset stretch
  logic link_rst_n_r; // Link reset from a flop, so decoding glitches never reach it
  logic [CW-1:0] seg_cnt_r; // Position within segment period
  logic [2:0] seg_num_r; // Next segment number, 1 to 4
  logic [1:0] frame_r; // 0 unique, 1 and 2 invalid
  logic [2:0] seg_idx_r; // Index of the latest ready segment
  logic seg_tgl_r; // Segment ready event toggle
  logic signed [2:0] offset_pend_r; // Offset waiting for a segment boundary
  logic signed [2:0] offset_r; // Offset in use
  logic mode_r; // Sync pin mode
  logic pin_r; // Pulse level
  logic [PW-1:0] pulse_cnt_r; // Pulse width counter
  logic loaded_r; // Offset ever loaded, checking only
  logic seen_r; // Pulse already given this segment, checking only

  // Decoding: ready sits three lines in so an early pulse still fits
  wire [CW-1:0] ready_at = CW'(MAX_OFFSET_LINES * LINE_CYC);
  wire [CW-1:0] pulse_at = CW'((MAX_OFFSET_LINES + int'(offset_r)) * LINE_CYC);
  wire seg_wrap = (seg_cnt_r == CW'(SEG_CYC - 1));
  wire link_busy = (link_rst_cnt_r != 3'h0);
  wire idle_done = i_ce && cs_s_r && (idle_cnt_r == RW'(RESYNC_CYC - 1));
  // A ready that meets a timeout is dropped whole, never half applied
  wire seg_ready = i_ce && (seg_cnt_r == ready_at) && !link_busy && !idle_done;
  wire pulse_start = i_ce && mode_r && (seg_cnt_r == pulse_at);
  // A code of minus four is clamped to minus three
  wire signed [2:0] offset_in = (i_pulse_offset == 3'h4) ? -3'sd3 : $signed(i_pulse_offset);

  assign lnk.seg_tgl = seg_tgl_r;
  assign lnk.seg_idx = seg_idx_r;
  assign lnk.tlm_en = i_telemetry_en;
  assign lnk.colour_fmt = i_colour_fmt;
  assign lnk.link_rst_n = link_rst_n_r;
  assign o_general_pin_three = pin_r;
  assign o_general_pin_three_oe = mode_r;

  // Select crosses two flops before any use
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
    end else if (i_ce) begin
      cs_m_r <= i_spi_cs_n;
      cs_s_r <= cs_m_r;
    end
  end

  // Idle timeout; serial clock is stopped then, so the link reset is safe
  // Only the select is watched; a clock toggling while deselected goes unseen
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      idle_cnt_r <= '0;
      link_rst_cnt_r <= LINK_RST_CYC;
      link_rst_n_r <= 1'b0;
    end else if (i_ce) begin
      // Released in the same cycle as the stretch counter reaches zero
      link_rst_n_r <= !(idle_done || (link_rst_cnt_r > 3'h1));
      if (!cs_s_r) begin
        idle_cnt_r <= '0;
      end else if (idle_cnt_r != RW'(RESYNC_CYC)) begin
        idle_cnt_r <= idle_cnt_r + RW'(1);
      end
      if (idle_done) begin
        link_rst_cnt_r <= LINK_RST_CYC;
      end else if (link_busy) begin
        link_rst_cnt_r <= link_rst_cnt_r - 3'h1;
      end
    end
  end

  // Segment period counter
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      seg_cnt_r <= '0;
    end else if (i_ce) begin
      seg_cnt_r <= seg_wrap ? '0 : seg_cnt_r + CW'(1);
    end
  end

  // Segment numbering: unique frame 1..4, then two frames of zeros
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      seg_num_r <= 3'h1;
      frame_r <= 2'h0;
      seg_idx_r <= 3'h0;
      seg_tgl_r <= 1'b0;
    end else if (i_ce && idle_done) begin
      seg_tgl_r <= 1'b0; // Matches the link synchroniser reset
    end else if (seg_ready) begin
      seg_tgl_r <= ~seg_tgl_r;
      seg_idx_r <= (frame_r == 2'h0) ? seg_num_r : 3'h0;
      if (seg_num_r == 3'(SEGS_PER_FRAME)) begin
        seg_num_r <= 3'h1;
        frame_r <= (frame_r == 2'(INVALID_FRAMES)) ? 2'h0 : frame_r + 2'h1;
      end else begin
        seg_num_r <= seg_num_r + 3'h1;
      end
    end
  end

  // Offset takes effect only at a segment boundary, so no segment gets two
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      offset_pend_r <= 3'sd0;
      offset_r <= 3'sd0;
      mode_r <= 1'b0;
    end else if (i_ce) begin
      mode_r <= i_vsync_mode;
      if (i_offset_load) begin
        offset_pend_r <= offset_in;
      end
      if (seg_wrap) begin
        offset_r <= offset_pend_r;
      end
    end
  end

  // Pulse generator, one fixed-width pulse per segment
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_r <= 1'b0;
      pulse_cnt_r <= '0;
    end else if (i_ce) begin
      if (!i_vsync_mode) begin
        pin_r <= 1'b0; // Falls with the enable, never driven without it
      end else if (pulse_start) begin
        pin_r <= 1'b1;
        pulse_cnt_r <= PW'(PULSE_CYC - 1);
      end else if (pulse_cnt_r == '0) begin
        pin_r <= 1'b0;
      end else begin
        pulse_cnt_r <= pulse_cnt_r - PW'(1);
      end
    end
  end

  // Checking helpers
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      loaded_r <= 1'b0;
      seen_r <= 1'b0;
    end else if (i_ce) begin
      if (i_offset_load) begin
        loaded_r <= 1'b1;
      end
      seen_r <= seg_wrap ? 1'b0 : (seen_r || pulse_start);
    end
  end

  spi_packet_tx u_tx (
    .i_spi_clk(i_spi_clk),
    .i_spi_cs_n(i_spi_cs_n),
    .o_spi_miso(o_spi_miso),
    .lnk(lnk)
  );

  default clocking cc @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_timeout;
    idle_done;
  endsequence
  sequence s_link_held;
    !lnk.link_rst_n [*4];
  endsequence
  a_pin_needs_mode: assert property (o_general_pin_three |-> o_general_pin_three_oe)
    else $error("pulse driven while sync mode is off");
  a_pulse_at_offset: assert property (pulse_start && i_vsync_mode |=> o_general_pin_three)
    else $error("pulse missing at offset position");
  a_pulse_rise_cause: assert property ($rose(o_general_pin_three) |-> $past(pulse_start))
    else $error("pulse rose away from its offset position");
  a_offset_reset_zero: assert property (!loaded_r |-> offset_r == 3'sd0)
    else $error("offset not zero before any load");
  a_one_pulse_seg: assert property (pulse_start |-> !seen_r)
    else $error("second pulse within one segment");
  a_seg_index_seq: assert property (seg_ready && frame_r != 2'h0 |=> seg_idx_r == 3'h0)
    else $error("invalid frame segment index not zero");
  a_seg_index_uniq: assert property (seg_ready && frame_r == 2'h0 |=>
    seg_idx_r == $past(seg_num_r) && seg_idx_r != 3'h0)
    else $error("unique frame segment index wrong");
  a_timeout_reset: assert property (s_timeout |=> s_link_held)
    else $error("link not restarted after idle timeout");
  a_ready_toggle: assert property (seg_ready |=> seg_tgl_r != $past(seg_tgl_r))
    else $error("segment ready not passed to link");
endmodule

// ---- dv/spi_host_model.sv ----
// Host master of the video link: clocks packets out of the device
`timescale 1ns/1ps
module spi_host_model (
  // Serial link
  output logic o_spi_clk,
  output logic o_spi_cs_n,
  input wire logic i_spi_miso
);
  localparam int HALF_NS = 15; // Half of the 30 ns link clock
  localparam int LEAD_NS = 7; // Select lead, keeps link edges off core edges
  logic [7:0] rx_q[$]; // Bytes taken from the link, oldest first

  // Clock idles high and stands still outside transfers
  initial begin
    o_spi_clk = 1'b1;
    o_spi_cs_n = 1'b1;
  end

  // Clock in n bytes, MSB first; sample on the fall, device shifts on the rise
  task automatic read_bytes(input int n);
    logic [7:0] b;
    b = 8'h00;
    if (o_spi_cs_n) begin
      o_spi_cs_n = 1'b0;
      #(LEAD_NS);
    end
    for (int i = 0; i < n; i++) begin // Callers ask for a header, or a packet's bytes after its header
      for (int j = 0; j < 8; j++) begin
        o_spi_clk = 1'b0;
        b = {b[6:0], i_spi_miso};
        #(HALF_NS);
        o_spi_clk = 1'b1;
        #(HALF_NS);
      end
      rx_q.push_back(b);
    end
  endtask

  // Deselect with clock idle; long enough forces a link restart
  task automatic idle(input int ns);
    o_spi_cs_n = 1'b1;
    #(ns);
  endtask
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the segment timing core and its video link
`timescale 1ns/1ps
module tb_top;
  import vspi_pkg::*;
  localparam int SEG_T = 14000; // Shortened segment period, core cycles
  localparam int LINE_T = 100; // Shortened line period
  localparam int IDLE_T = 500; // Shortened resync idle
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_vsync_mode = 1'b0;
  logic i_colour_fmt = 1'b0;
  logic i_telemetry_en = 1'b0;
  logic i_offset_load = 1'b0;
  logic [2:0] i_pulse_offset = 3'h0;
  logic spi_clk, spi_cs_n, spi_miso, pin, pin_oe;
  logic loading = 1'b0; // Keeps the random driver off the offset bus
  int fails = 0;
  int check_count = 0;
  int seed = 26;
  int rnd;
  int cyc = 0; // Core cycles since reset release
  int seg_n = 0; // Segments read so far
  int rise_q[$]; // Pulse rise times, in cycles

  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) cyc <= i_nrst ? cyc + 1 : 0;

  video_spi_segment_sync #(.SEG_CYC(SEG_T), .LINE_CYC(LINE_T), .RESYNC_CYC(IDLE_T)) dut_u (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_spi_clk(spi_clk), .i_spi_cs_n(spi_cs_n),
    .o_spi_miso(spi_miso), .i_vsync_mode(i_vsync_mode), .i_telemetry_en(i_telemetry_en),
    .i_colour_fmt(i_colour_fmt), .i_offset_load(i_offset_load), .i_pulse_offset(i_pulse_offset),
    .o_general_pin_three(pin), .o_general_pin_three_oe(pin_oe));
  spi_host_model host_u (.o_spi_clk(spi_clk), .o_spi_cs_n(spi_cs_n), .i_spi_miso(spi_miso));

  // Compare and count; a mismatch is reported at once
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Four bytes off the host queue, first byte most significant
  task automatic pop_word(output logic [31:0] v);
    v = '0;
    for (int k = 0; k < 4; k++) v = {v[23:0], host_u.rx_q.pop_front()};
  endtask

  // Half-row test pattern: raw {row,col}, colour {row,col,pkt}
  task automatic check_payload(input int pkt, input logic colour);
    int w;
    w = colour ? RGB_BYTES_PER_PIX : RAW_BYTES_PER_PIX;
    for (int p = 0; p < HALF_ROW_PIXELS; p++) begin
      for (int k = 0; k < w; k++) begin
        check(host_u.rx_q.pop_front(), k == 0 ? pkt / 2 : k == 1 ? (pkt % 2) * 80 + p : pkt);
      end
    end
  endtask

  // Read one segment's first packets, then drop sync on purpose and resync
  task automatic get_segment(input logic colour);
    int len;
    int exp_idx;
    logic [31:0] hdr;
    logic found;
    len = colour ? RGB_PKT_BYTES : RAW_PKT_BYTES;
    exp_idx = (seg_n % 12 < 4) ? seg_n % 12 + 1 : 0;
    found = 1'b0;
    @(posedge i_clk);
    #1 i_colour_fmt = colour;
    i_telemetry_en = (seg_n == 3); // One segment with the extra packet
    // Skip discard packets until the video one, bounded
    for (int n = 0; n < 8 && !found; n++) begin
      host_u.rx_q.delete();
      host_u.read_bytes(HDR_BYTES);
      pop_word(hdr);
      if (hdr[31:24] === DISCARD_ID_HI) host_u.read_bytes(len - HDR_BYTES);
      else found = 1'b1;
    end
    check(found, 1'b1);
    check(hdr, {1'b0, exp_idx[2:0], 4'h0, 8'h00, 16'h0000});
    host_u.read_bytes(len - HDR_BYTES);
    check_payload(0, colour);
    // Next header sits right after a packet of the format's length
    host_u.read_bytes(HDR_BYTES);
    pop_word(hdr);
    check(hdr, {1'b0, exp_idx[2:0], 4'h0, 8'h01, 16'h0000});
    if (!colour) begin
      host_u.read_bytes(len - HDR_BYTES);
      check_payload(1, 1'b0);
    end
    host_u.idle(7000); // Segment left unfinished, so a resync is needed
    seg_n++;
    $display("Segment test %0d done, index %0d", seg_n, exp_idx);
  endtask

  // Junk on the offset bus while no load is strobed; it must be ignored
  always @(posedge i_clk) begin
    #1;
    rnd = $random(seed);
    if (!loading) i_pulse_offset = rnd[2:0];
  end

  // Log each pulse rise and check its width
  always @(posedge pin) begin
    #1; // Cycle counter settles after the launching edge
    rise_q.push_back(cyc);
    check(pin_oe, 1'b1);
    repeat (PULSE_CYC - 1) @(posedge i_clk);
    #1 check(pin, 1'b1);
    @(posedge i_clk);
    #1 check(pin, 1'b0);
  end

  // Bounded wait until n pulses have been seen
  task automatic wait_rise(input int n);
    for (int c = 0; c < 3 * SEG_T && rise_q.size() < n; c++) @(posedge i_clk);
    check(rise_q.size() >= n, 1'b1);
  endtask

  // Load an offset with a one-cycle strobe
  task automatic load_offset(input logic [2:0] v);
    @(posedge i_clk);
    #1 loading = 1'b1;
    @(posedge i_clk);
    #1 i_pulse_offset = v;
    i_offset_load = 1'b1;
    @(posedge i_clk);
    #1 i_offset_load = 1'b0;
    @(posedge i_clk);
    #1 loading = 1'b0;
  endtask

  // Offset table: -3, +3, then -4 which clamps to -3
  logic [2:0] off_v[3] = '{3'h5, 3'h3, 3'h4};
  int off_e[4] = '{0, -3, 3, -3};

  initial begin
    repeat (6) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    repeat (10) @(posedge i_clk);
    fork
      for (int k = 0; k < 5; k++) get_segment(k == 4);
      begin
        repeat (1000) @(posedge i_clk);
        check(rise_q.size(), 0);
        check(pin_oe, 1'b0);
        #1 i_vsync_mode = 1'b1;
        wait_rise(1);
        check(rise_q[0] % SEG_T >= 3 * LINE_T && rise_q[0] % SEG_T <= 3 * LINE_T + 4, 1'b1);
        for (int i = 0; i < 3; i++) begin
          load_offset(off_v[i]);
          wait_rise(i + 2);
          check(rise_q[i + 1] - rise_q[i], SEG_T + (off_e[i + 1] - off_e[i]) * LINE_T);
        end
        $display("Pulse offset test done");
      end
    join
    stop_test();
  end

  // Watchdog well past the expected run of about 66500 cycles
  initial begin
    #900000;
    fails++;
    stop_test();
  end
endmodule
